// ### common/ccd_pkg.sv
// ccd_pkg: constants for the per-channel clock divider configuration block
// assumes a plain register port with 8-bit word addresses and 16-bit data
package ccd_pkg;

    localparam int unsigned CCD_ADDR_W    = 8;
    localparam int unsigned CCD_DATA_W    = 16;
    localparam int unsigned CCD_NUM_CH    = 3;
    localparam int unsigned CCD_DIV_W     = 10;
    localparam int unsigned CCD_SEL_W     = 2;

    // register offsets (word addresses)
    localparam logic [7:0]  CCD_CH1_CLK_OFS = 8'h15;
    localparam logic [7:0]  CCD_CH2_CLK_OFS = 8'h16;
    localparam logic [7:0]  CCD_CH3_CLK_OFS = 8'h17;

    // field positions
    localparam int unsigned CCD_RSVH_MSB  = 15;
    localparam int unsigned CCD_RSVH_LSB  = 14;
    localparam int unsigned CCD_SEL_MSB   = 13;
    localparam int unsigned CCD_SEL_LSB   = 12;
    localparam int unsigned CCD_RSVL_MSB  = 11;
    localparam int unsigned CCD_RSVL_LSB  = 10;
    localparam int unsigned CCD_DIV_MSB   = 9;
    localparam int unsigned CCD_DIV_LSB   = 0;

    // reset value of each divider register
    localparam logic [15:0] CCD_CLK_RST   = 16'h0000;

    // sensor frequency select encodings
    typedef enum logic [1:0] {
        CCD_SEL_OFF  = 2'b00,
        CCD_SEL_DIV1 = 2'b01,
        CCD_SEL_DIV2 = 2'b10,
        CCD_SEL_RSV  = 2'b11
    } ccd_sel_t;

    localparam logic [9:0]  CCD_DIV_ZERO  = 10'h000;
    localparam logic [9:0]  CCD_DIV_ONE   = 10'h001;
    localparam logic [15:0] CCD_RD_UNMAP  = 16'h0000;

endpackage

// ### rtl/ccd_ref_div.sv
// ccd_ref_div: divides the master clock by a programmable 10-bit value
// assumes div_i is held stable; a change is compared against the running count at once, without a restart
`timescale 1ns/1ps
module ccd_ref_div
    import ccd_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    // divider setting
    input  wire logic [CCD_DIV_W-1:0] div_i,
    // reference clock out
    output logic                      ref_clk_o,
    output logic                      ref_tick_o,
    output logic                      ref_valid_o
);

    logic [CCD_DIV_W-1:0] cnt_r;
    logic [CCD_DIV_W-1:0] cnt_nxt;
    logic                 clk_r;
    logic                 clk_nxt;
    logic                 tick_r;
    logic                 tick_nxt;
    logic                 valid_r;
    logic                 valid_nxt;

    always_comb begin
        cnt_nxt   = cnt_r;
        clk_nxt   = clk_r;
        tick_nxt  = 1'b0;
        valid_nxt = (div_i != CCD_DIV_ZERO);
        if (div_i == CCD_DIV_ZERO) begin
            // reserved code: hold the clock low rather than run undefined
            cnt_nxt = CCD_DIV_ZERO;
            clk_nxt = 1'b0;
        end else if (div_i == CCD_DIV_ONE) begin
            // divide by one: tick every cycle, level mirrors the enable
            cnt_nxt  = CCD_DIV_ZERO;
            clk_nxt  = 1'b1;
            tick_nxt = 1'b1;
        end else if (cnt_r >= div_i - CCD_DIV_ONE) begin
            cnt_nxt  = CCD_DIV_ZERO;
            clk_nxt  = 1'b1;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + CCD_DIV_ONE;
            // high for the first half of the period, rounded down
            clk_nxt = ((cnt_r + CCD_DIV_ONE) < (div_i >> 1));
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r   <= '0;
            clk_r   <= 1'b0;
            tick_r  <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            clk_r   <= clk_nxt;
            tick_r  <= tick_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign ref_clk_o   = clk_r;
    assign ref_tick_o  = tick_r;
    assign ref_valid_o = valid_r;

endmodule // ccd_ref_div

// ### rtl/ccd_clock_cfg.sv
// ccd_clock_cfg: clock divider configuration registers for channels 1..3
// assumes a one-clock register port, read data valid in the cycle after the strobe
//
// How it works
// - select 01 divides sensor frequency by one
// - select 10 divides sensor frequency by two
// - reference clock is master clock over divider
// - one divider register per channel, 0x15-0x17
`timescale 1ns/1ps
module ccd_clock_cfg
    import ccd_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    // register port
    input  wire logic [CCD_ADDR_W-1:0] addr_i,
    input  wire logic [CCD_DATA_W-1:0] wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [CCD_DATA_W-1:0] rdata_o,
    // channel 1
    output logic                       ch1_reference_clock_o,
    output logic                       ch1_ref_tick_o,
    output logic                       ch1_ref_valid_o,
    output logic      [CCD_SEL_W-1:0]  ch1_sensor_freq_select_o,
    output logic                       ch1_sensor_div2_o,
    output logic                       ch1_sensor_sel_valid_o,
    // channel 2
    output logic                       ch2_reference_clock_o,
    output logic                       ch2_ref_tick_o,
    output logic                       ch2_ref_valid_o,
    output logic      [CCD_SEL_W-1:0]  ch2_sensor_freq_select_o,
    output logic                       ch2_sensor_div2_o,
    output logic                       ch2_sensor_sel_valid_o,
    // channel 3
    output logic                       ch3_reference_clock_o,
    output logic                       ch3_ref_tick_o,
    output logic                       ch3_ref_valid_o,
    output logic      [CCD_SEL_W-1:0]  ch3_sensor_freq_select_o,
    output logic                       ch3_sensor_div2_o,
    output logic                       ch3_sensor_sel_valid_o
);

    // returns the channel index hit by an address, or CCD_NUM_CH on a miss
    function automatic logic [1:0] ch_index(input logic [CCD_ADDR_W-1:0] a);
        logic [1:0] idx;
        idx = 2'h3;
        unique case (a)
            CCD_CH1_CLK_OFS: idx = 2'h0;
            CCD_CH2_CLK_OFS: idx = 2'h1;
            CCD_CH3_CLK_OFS: idx = 2'h2;
            default:         idx = 2'h3;
        endcase
        return idx;
    endfunction

    // code returned by ch_index when no divider register is addressed
    localparam logic [1:0] CH_MISS = 2'h3;

    // reference divider field of a stored word
    function automatic logic [CCD_DIV_W-1:0] div_field(input logic [CCD_DATA_W-1:0] w);
        return w[CCD_DIV_MSB:CCD_DIV_LSB];
    endfunction

    // sensor frequency select field of a stored word
    function automatic logic [CCD_SEL_W-1:0] sel_field(input logic [CCD_DATA_W-1:0] w);
        return w[CCD_SEL_MSB:CCD_SEL_LSB];
    endfunction

    // sensor divide decode: 01 is one, 10 is two, 00 and 11 are not valid
    function automatic logic sel_div2(input logic [CCD_SEL_W-1:0] s);
        return (s == CCD_SEL_DIV2);
    endfunction

    function automatic logic sel_ok(input logic [CCD_SEL_W-1:0] s);
        return (s == CCD_SEL_DIV1) || (s == CCD_SEL_DIV2);
    endfunction

    // read mux: a miss reads as the unmapped value, never as a stale word
    function automatic logic [CCD_DATA_W-1:0] rd_word(
        input logic [1:0]            idx,
        input logic [CCD_DATA_W-1:0] w0,
        input logic [CCD_DATA_W-1:0] w1,
        input logic [CCD_DATA_W-1:0] w2
    );
        logic [CCD_DATA_W-1:0] res;
        res = CCD_RD_UNMAP;
        unique case (idx)
            2'h0:    res = w0;
            2'h1:    res = w1;
            2'h2:    res = w2;
            default: res = CCD_RD_UNMAP;
        endcase
        return res;
    endfunction

    logic [CCD_DATA_W-1:0] cfg_r   [CCD_NUM_CH];
    logic [CCD_DATA_W-1:0] cfg_nxt [CCD_NUM_CH];
    logic [CCD_DATA_W-1:0] rdata_r;
    logic [CCD_DATA_W-1:0] rdata_nxt;
    logic [1:0]            widx;
    logic [1:0]            ridx;

    // decoded sensor divide flags, registered beside the words they come from
    logic                  div2_r   [CCD_NUM_CH];
    logic                  div2_nxt [CCD_NUM_CH];
    logic                  selv_r   [CCD_NUM_CH];
    logic                  selv_nxt [CCD_NUM_CH];

    logic [CCD_DIV_W-1:0]  div_w   [CCD_NUM_CH];
    logic [CCD_SEL_W-1:0]  sel_w   [CCD_NUM_CH];
    logic                  rclk_w  [CCD_NUM_CH];
    logic                  rtick_w [CCD_NUM_CH];
    logic                  rval_w  [CCD_NUM_CH];

    // one decode serves both strobes; they never come together
    assign widx = ch_index(addr_i);
    assign ridx = ch_index(addr_i);

    // reserved bits are stored as written so the host reads back its own value
    always_comb begin
        for (int i = 0; i < CCD_NUM_CH; i++) begin
            cfg_nxt[i] = cfg_r[i];
        end
        if (wr_i && (widx != CH_MISS)) begin
            cfg_nxt[widx] = wdata_i;
        end
    end

    // read data hold between reads; the host takes them in the cycle after its strobe
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_i) begin
            rdata_nxt = rd_word(ridx, cfg_r[0], cfg_r[1], cfg_r[2]);
        end
    end

    // configuration words; reserved pairs are kept exactly as written
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < CCD_NUM_CH; i++) begin
                cfg_r[i] <= CCD_CLK_RST;
            end
        end else begin
            for (int i = 0; i < CCD_NUM_CH; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_r <= CCD_RD_UNMAP;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // flags follow the next word so they change on the same edge as the field
    always_comb begin
        for (int i = 0; i < CCD_NUM_CH; i++) begin
            div2_nxt[i] = sel_div2(sel_field(cfg_nxt[i]));
            selv_nxt[i] = sel_ok(sel_field(cfg_nxt[i]));
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < CCD_NUM_CH; i++) begin
                div2_r[i] <= 1'b0;
                selv_r[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < CCD_NUM_CH; i++) begin
                div2_r[i] <= div2_nxt[i];
                selv_r[i] <= selv_nxt[i];
            end
        end
    end

    assign rdata_o = rdata_r;

    // per-channel field split and reference divider
    for (genvar g = 0; g < CCD_NUM_CH; g++) begin : g_ch
        assign div_w[g] = div_field(cfg_r[g]);
        assign sel_w[g] = sel_field(cfg_r[g]);

        // divider zero holds the clock still; the host must avoid it
        ccd_ref_div u_ref_div (
            .clk_i       (clk_i),
            .nrst_i      (nrst_i),
            .div_i       (div_w[g]),
            .ref_clk_o   (rclk_w[g]),
            .ref_tick_o  (rtick_w[g]),
            .ref_valid_o (rval_w[g])
        );
    end

    // channel 1
    assign ch1_reference_clock_o    = rclk_w[0];
    assign ch1_ref_tick_o           = rtick_w[0];
    assign ch1_ref_valid_o          = rval_w[0];
    assign ch1_sensor_freq_select_o = sel_w[0];
    assign ch1_sensor_div2_o        = div2_r[0];
    assign ch1_sensor_sel_valid_o   = selv_r[0];

    // channel 2
    assign ch2_reference_clock_o    = rclk_w[1];
    assign ch2_ref_tick_o           = rtick_w[1];
    assign ch2_ref_valid_o          = rval_w[1];
    assign ch2_sensor_freq_select_o = sel_w[1];
    assign ch2_sensor_div2_o        = div2_r[1];
    assign ch2_sensor_sel_valid_o   = selv_r[1];

    // channel 3
    assign ch3_reference_clock_o    = rclk_w[2];
    assign ch3_ref_tick_o           = rtick_w[2];
    assign ch3_ref_valid_o          = rval_w[2];
    assign ch3_sensor_freq_select_o = sel_w[2];
    assign ch3_sensor_div2_o        = div2_r[2];
    assign ch3_sensor_sel_valid_o   = selv_r[2];

endmodule // ccd_clock_cfg

// ### verif/ccd_clock_cfg_assertions.sv
// ccd_chk: port-level checks of the divider configuration block
// assumes the one-cycle register port of ccd_clock_cfg
`timescale 1ns/1ps
module ccd_chk
    import ccd_pkg::*;
(
    input wire logic                  clk_i,
    input wire logic                  nrst_i,
    input wire logic [CCD_ADDR_W-1:0] addr_i,
    input wire logic [CCD_DATA_W-1:0] wdata_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire logic [CCD_DATA_W-1:0] rdata_o,
    input wire logic                  ch1_ref_tick_o,
    input wire logic [CCD_SEL_W-1:0]  ch1_sensor_freq_select_o,
    input wire logic                  ch1_sensor_div2_o,
    input wire logic                  ch1_sensor_sel_valid_o,
    input wire logic [CCD_SEL_W-1:0]  ch2_sensor_freq_select_o,
    input wire logic [CCD_SEL_W-1:0]  ch3_sensor_freq_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic [1:0] wsel;
    logic       hit;
    assign wsel = wdata_i[13:12];
    assign hit  = addr_i inside {CCD_CH1_CLK_OFS, CCD_CH2_CLK_OFS, CCD_CH3_CLK_OFS};
    a_unmap_read: assert property (rd_i && !hit |=> rdata_o == CCD_RD_UNMAP)
        else $error("unmapped read not zero");
    a_ch1_store: assert property (wr_i && addr_i == CCD_CH1_CLK_OFS |=>
        ch1_sensor_freq_select_o == $past(wsel)) else $error("ch1 select not stored");
    a_ch2_store: assert property (wr_i && addr_i == CCD_CH2_CLK_OFS |=>
        ch2_sensor_freq_select_o == $past(wsel)) else $error("ch2 select not stored");
    a_ch3_store: assert property (wr_i && addr_i == CCD_CH3_CLK_OFS |=>
        ch3_sensor_freq_select_o == $past(wsel)) else $error("ch3 select not stored");
    a_half_decode: assert property (ch1_sensor_div2_o == (ch1_sensor_freq_select_o == 2'b10))
        else $error("divide by two flag wrong");
    a_sel_valid: assert property (ch1_sensor_sel_valid_o ==
        (ch1_sensor_freq_select_o inside {2'b01, 2'b10})) else $error("select valid wrong");
    a_write_back: assert property (wr_i && addr_i == CCD_CH1_CLK_OFS ##1
        rd_i && addr_i == CCD_CH1_CLK_OFS |=> rdata_o == $past(wdata_i, 2))
        else $error("read back differs");
    a_read_holds: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without read");
    cover property (wr_i && addr_i == CCD_CH1_CLK_OFS);
    cover property (rd_i && !hit);
    cover property (ch1_ref_tick_o);
    cover property (wr_i ##1 rd_i);
endmodule // ccd_chk
bind ccd_clock_cfg ccd_chk u_chk (
    .clk_i                    (clk_i),
    .nrst_i                   (nrst_i),
    .addr_i                   (addr_i),
    .wdata_i                  (wdata_i),
    .wr_i                     (wr_i),
    .rd_i                     (rd_i),
    .rdata_o                  (rdata_o),
    .ch1_ref_tick_o           (ch1_ref_tick_o),
    .ch1_sensor_freq_select_o (ch1_sensor_freq_select_o),
    .ch1_sensor_div2_o        (ch1_sensor_div2_o),
    .ch1_sensor_sel_valid_o   (ch1_sensor_sel_valid_o),
    .ch2_sensor_freq_select_o (ch2_sensor_freq_select_o),
    .ch3_sensor_freq_select_o (ch3_sensor_freq_select_o)
);

// ### verif/ccd_host.sv
// ccd_host: host model on the register port of the divider block
// assumes its tasks are entered right after a rising clock edge
`timescale 1ns/1ps
module ccd_host
    import ccd_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic [CCD_DATA_W-1:0] rdata_i,
    output logic      [CCD_ADDR_W-1:0] addr_o = 8'h00,
    output logic      [CCD_DATA_W-1:0] wdata_o = 16'h0000,
    output logic                       wr_o = 1'b0,
    output logic                       rd_o = 1'b0
);
    // reserved pairs forced to zero, a zero divider bumped to one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_o  <= a;
        wdata_o <= (d & 16'h33FF) | {15'h0000, d[9:0] == 10'h000};
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        @(posedge clk_i);
    endtask
    // write then read with no idle cycle between the two strobes
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        addr_o  <= a;
        wdata_o <= (d & 16'h33FF) | {15'h0000, d[9:0] == 10'h000};
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        rd_o    <= 1'b1;
        @(posedge clk_i);
        rd_o    <= 1'b0;
        @(posedge clk_i);
        q = rdata_i;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule // ccd_host

// ### verif/ccd_clock_cfg_tb.sv
// ccd_clock_cfg_tb: register and reference clock checks of the divider block
// assumes ccd_host drives the register port
`timescale 1ns/1ps
module ccd_clock_cfg_tb;
    import ccd_pkg::*;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, r, p, hi;
    logic        wr, rd;
    wire  [2:0]  rclk, tick, val, div2, selv;
    wire  [1:0]  sel [3];
    logic [1:0]  s;
    logic [15:0] cfg [6] = '{16'h1004, 16'h2003, 16'h1001, 16'h2001, 16'h13FF, 16'h2002};
    int          errors = 0;
    int          n_compared = 0;
    always #50 clk_i = ~clk_i;
    ccd_host u_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    ccd_clock_cfg u_ccd_clock_cfg (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .ch1_reference_clock_o(rclk[0]), .ch1_ref_tick_o(tick[0]), .ch1_ref_valid_o(val[0]),
        .ch1_sensor_freq_select_o(sel[0]), .ch1_sensor_div2_o(div2[0]),
        .ch1_sensor_sel_valid_o(selv[0]),
        .ch2_reference_clock_o(rclk[1]), .ch2_ref_tick_o(tick[1]), .ch2_ref_valid_o(val[1]),
        .ch2_sensor_freq_select_o(sel[1]), .ch2_sensor_div2_o(div2[1]),
        .ch2_sensor_sel_valid_o(selv[1]),
        .ch3_reference_clock_o(rclk[2]), .ch3_ref_tick_o(tick[2]), .ch3_ref_valid_o(val[2]),
        .ch3_sensor_freq_select_o(sel[2]), .ch3_sensor_div2_o(div2[2]),
        .ch3_sensor_sel_valid_o(selv[2]));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // cycles between two ticks and reference clock high cycles among them,
    // sampled before each edge updates
    task automatic period(input int c, output logic [15:0] q, output logic [15:0] h);
        int n;
        n = 0;
        while (tick[c] !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        q = 16'h0000;
        h = 16'h0000;
        do begin
            @(posedge clk_i);
            q++;
            if (rclk[c] === 1'b1) begin
                h++;
            end
        end while (tick[c] !== 1'b1 && q < 16'd2000);
        if (n >= 2000 || q >= 16'd2000) begin
            errors++;
            print_verdict();
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        for (int c = 0; c < 3; c++) begin
            u_host.rd(CCD_CH1_CLK_OFS + 8'(c), r);
            chk("reset value", CCD_CLK_RST, r);
            chk("reset fields", 16'h0000, {11'h000, val[c], div2[c], selv[c], sel[c]});
        end
        for (int k = 0; k < 6; k += 3) begin
            for (int c = 0; c < 3; c++) u_host.wr(CCD_CH1_CLK_OFS + 8'(c), cfg[k + c]);
            for (int c = 0; c < 3; c++) begin
                u_host.rd(CCD_CH1_CLK_OFS + 8'(c), r);
                chk("read back", cfg[k + c], r);
                s = cfg[k + c][13:12];
                chk("select", {11'h000, 1'b1, s == 2'b10, s inside {2'b01, 2'b10}, s},
                    {11'h000, val[c], div2[c], selv[c], sel[c]});
                period(c, p, hi);
                chk("ref period", {6'h00, cfg[k + c][9:0]}, p);
                // one high cycle per period at divide by one, else half rounded down
                chk("ref high", (cfg[k + c][9:0] == 10'h001) ? 16'h0001
                    : {7'h00, cfg[k + c][9:1]}, hi);
            end
        end
        u_host.wr(CCD_CH3_CLK_OFS, 16'h3003);
        chk("select 11", {11'h000, 1'b1, 1'b0, 1'b0, 2'b11},
            {11'h000, val[2], div2[2], selv[2], sel[2]});
        u_host.wr(8'h14, 16'h1005);
        u_host.rd(8'h14, r);
        chk("unmapped 14", CCD_RD_UNMAP, r);
        u_host.rd(8'h18, r);
        chk("unmapped 18", CCD_RD_UNMAP, r);
        u_host.rd(CCD_CH1_CLK_OFS, r);
        chk("ch1 untouched", cfg[3], r);
        u_host.wr_rd(CCD_CH1_CLK_OFS, 16'h2005, r);
        chk("write then read", 16'h2005, r);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
endmodule // ccd_clock_cfg_tb
